// File: tba_request_answer.sv
// TypeB request decoder and answer sender with APB registers
//
// Summary of operation
// [R1] Answer the plain request only in the idle state, never in halt.
// [R2] Answer the wake-up request in halt, leaving halt to respond.
// [R3] Also answer the wake-up request in idle, same as the plain request.
// [R4] Ignore the three top bits of the parameter byte.
// [R5] Treat slot count as one and answer at once for every slot code.
// [R6] Family 0x0Y request: answer only when own family low nibble matches.
// [R7] Application data of the answer is four zero bytes.
// [R8] First protocol byte is 0x91: 106K and 212K, equal both ways.
// [R9] Second protocol byte 0x81: upper nibble 1000b, 256-byte frames.
// [R10] Second protocol byte lower nibble 0001b: transmission protocol supported.
// [R11] Reader waits 10 etu plus 32 subcarrier periods after the answer.
// [R12] Third protocol byte holds wait integer above, zero nibble below.
// [R13] Third byte bits 3-2 are 00b: proprietary data coding.
// [R14] Third byte bits 1-0 are 00b: no node address, no card id.
// [R15] Reader allows 256*16/fc times two to the wait integer, 0 to 14.
// [R16] Request is code 0x05, family, parameter, two CRC bytes; bad CRC ignored.
// [R17] Parameter bit 3 selects plain request (0) or wake-up (1).
// [R18] Answer is 0x50, id, four data bytes, three protocol bytes, CRC.
`timescale 1ns/1ps
module tba_request_answer (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Received frame bytes, CRC bytes included
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_last,
   input wire logic rx_crc_ok,
   // Answer bytes, CRC appended downstream after tx_last
   output logic tx_valid,
   output logic [7:0] tx_data,
   output logic tx_last,
   input wire logic tx_ready
);
   // Registers
   logic [31:0] ctrl_reg;
   logic [31:0] ctrl_next;
   logic [31:0] pupi_reg;
   logic [31:0] pupi_next;
   tba_pkg::tba_state_t state_reg;
   tba_pkg::tba_state_t state_next;
   logic [7:0] cnt_reg;
   logic [7:0] cnt_next;
   logic [2:0] rxcnt_reg;
   logic [2:0] rxcnt_next;
   logic [7:0] code_reg;
   logic [7:0] code_next;
   logic [7:0] afi_reg;
   logic [7:0] afi_next;
   logic [7:0] param_reg;
   logic [7:0] param_next;
   logic send_reg;
   logic send_next;
   logic [3:0] idx_reg;
   logic [3:0] idx_next;
   logic [31:0] prdata_next;

   // APB decode
   wire apb_setup = psel && !penable;
   wire apb_acc = psel && penable;
   wire hit_ctrl = paddr == tba_pkg::TBA_CTRL_OFF;
   wire hit_pupi = paddr == tba_pkg::TBA_PUPI_OFF;
   wire hit_stat = paddr == tba_pkg::TBA_STAT_OFF;
   wire hit_cmd = paddr == tba_pkg::TBA_CMD_OFF;
   wire hit_any = hit_ctrl || hit_pupi || hit_stat || hit_cmd;
   wire wr_ctrl = apb_acc && pwrite && hit_ctrl;
   wire wr_pupi = apb_acc && pwrite && hit_pupi;
   wire wr_cmd = apb_acc && pwrite && hit_cmd;
   wire force_idle = wr_cmd && pwdata[tba_pkg::TBA_CMD_IDLE_BIT];
   wire force_halt = wr_cmd && pwdata[tba_pkg::TBA_CMD_HALT_BIT];

   // Control fields
   wire enable = ctrl_reg[tba_pkg::TBA_CTRL_EN_BIT];
   wire [3:0] fwi = ctrl_reg[tba_pkg::TBA_CTRL_FWI_LSB +: 4];
   wire [7:0] own_afi = ctrl_reg[tba_pkg::TBA_CTRL_AFI_LSB +: 8];

   wire [31:0] stat_word = {16'h0000, cnt_reg, 5'h00, send_reg, state_reg};

   assign pready = 1'b1;
   assign pslverr = apb_acc && !hit_any;
   assign prdata_next = !(apb_setup && !pwrite) ? prdata :
                        hit_ctrl ? ctrl_reg :
                        hit_pupi ? pupi_reg :
                        hit_stat ? stat_word : 32'h0000_0000;
   assign ctrl_next = wr_ctrl ? pwdata : ctrl_reg;
   assign pupi_next = wr_pupi ? pwdata : pupi_reg;

   // Frame byte capture; requests arriving while sending are dropped
   wire rx_take = rx_valid && !send_reg;
   wire rx_end = rx_take && rx_last;
   assign rxcnt_next = rx_end ? 3'h0 :
                       (rx_take && rxcnt_reg != 3'h7) ? rxcnt_reg + 3'h1 : rxcnt_reg;
   assign code_next = (rx_take && rxcnt_reg == 3'h0) ? rx_data : code_reg;
   assign afi_next = (rx_take && rxcnt_reg == 3'h1) ? rx_data : afi_reg;
   assign param_next = (rx_take && rxcnt_reg == 3'h2) ? rx_data : param_reg;

   // [R16] Whole five-byte frame, right code, good CRC
   wire frame_ok = rx_end && rx_crc_ok && (rxcnt_reg == tba_pkg::TBA_REQ_LEN - 3'h1)
                   && code_reg == tba_pkg::TBA_REQ_CODE;

   // [R6] Family filter by nibble
   wire afi_hi_zero = afi_reg[7:4] == 4'h0;
   wire afi_lo_zero = afi_reg[3:0] == 4'h0;
   wire afi_hit = (afi_hi_zero && afi_lo_zero) ||
                  (afi_hi_zero && afi_reg[3:0] == own_afi[3:0]) ||
                  (afi_lo_zero && afi_reg[7:4] == own_afi[7:4]) ||
                  (afi_reg == own_afi);

   // [R17] Request type from parameter bit 3
   // [R4] [R5] Bits 7-5 and slot bits 2-0 never looked at
   wire is_wakeup = param_reg[tba_pkg::TBA_PARAM_WUP_BIT];

   // [R1] [R2] [R3] State gate per request type
   wire state_ok = (state_reg == tba_pkg::TBA_IDLE) ||
                   (is_wakeup && state_reg == tba_pkg::TBA_HALT);
   wire answer = frame_ok && afi_hit && state_ok && enable;

   // Answer sequencing
   wire tx_fire = send_reg && tx_ready;
   wire tx_done = tx_fire && idx_reg == tba_pkg::TBA_ANS_LAST;

   // [R5] Answer starts at once, single slot
   assign send_next = answer ? 1'b1 : tx_done ? 1'b0 : send_reg;
   assign idx_next = answer ? 4'h0 :
                     (tx_fire && !tx_done) ? idx_reg + 4'h1 : idx_reg;
   assign cnt_next = answer ? cnt_reg + 8'h01 : cnt_reg;

   // [R2] Wake-up in halt leaves halt for ready
   always_comb begin
      state_next = state_reg;
      if (force_halt) begin
         state_next = tba_pkg::TBA_HALT;
      end else if (force_idle) begin
         state_next = tba_pkg::TBA_IDLE;
      end else if (answer) begin
         state_next = tba_pkg::TBA_READY;
      end
   end

   assign tx_valid = send_reg;
   assign tx_last = send_reg && idx_reg == tba_pkg::TBA_ANS_LAST;

   // [R18] Answer bytes in order from the table
   tba_atqb_rom u_rom (
      .pclk(pclk),
      .presetn(presetn),
      .addr(idx_next),
      .pupi(pupi_reg),
      .fwi(fwi),
      .data_reg(tx_data)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= tba_pkg::TBA_CTRL_RST;
         pupi_reg <= tba_pkg::TBA_PUPI_RST;
         prdata <= 32'h0000_0000;
      end else begin
         ctrl_reg <= ctrl_next;
         pupi_reg <= pupi_next;
         prdata <= prdata_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= tba_pkg::TBA_IDLE;
         cnt_reg <= 8'h00;
         send_reg <= 1'b0;
         idx_reg <= 4'h0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         send_reg <= send_next;
         idx_reg <= idx_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rxcnt_reg <= 3'h0;
         code_reg <= 8'h00;
         afi_reg <= 8'h00;
         param_reg <= 8'h00;
      end else begin
         rxcnt_reg <= rxcnt_next;
         code_reg <= code_next;
         afi_reg <= afi_next;
         param_reg <= param_next;
      end
   end
endmodule

// File: tba_pkg.sv
// Constants shared by the TypeB request decoder and its answer builder
package tba_pkg;
   // APB register byte offsets
   localparam logic [7:0] TBA_CTRL_OFF = 8'h00;
   localparam logic [7:0] TBA_PUPI_OFF = 8'h04;
   localparam logic [7:0] TBA_STAT_OFF = 8'h08;
   localparam logic [7:0] TBA_CMD_OFF = 8'h0c;
   // Control register fields
   localparam int TBA_CTRL_EN_BIT = 0;
   localparam int TBA_CTRL_FWI_LSB = 4;
   localparam int TBA_CTRL_AFI_LSB = 8;
   // Command register fields
   localparam int TBA_CMD_IDLE_BIT = 0;
   localparam int TBA_CMD_HALT_BIT = 1;
   // Status register fields
   localparam int TBA_STAT_STATE_LSB = 0;
   localparam int TBA_STAT_BUSY_BIT = 2;
   localparam int TBA_STAT_CNT_LSB = 8;
   // Values after reset
   localparam logic [31:0] TBA_CTRL_RST = 32'h0000_0001;
   localparam logic [31:0] TBA_PUPI_RST = 32'h0000_0000;
   // Request frame
   localparam logic [7:0] TBA_REQ_CODE = 8'h05;
   localparam logic [2:0] TBA_REQ_LEN = 3'h5;
   localparam int TBA_PARAM_WUP_BIT = 3;
   // Answer frame
   localparam logic [7:0] TBA_ANS_CODE = 8'h50;
   localparam logic [7:0] TBA_PROTO1 = 8'h91;
   localparam logic [3:0] TBA_MAXFRAME = 4'h8;
   localparam logic [3:0] TBA_PROTYPE = 4'h1;
   localparam logic [1:0] TBA_ADC = 2'h0;
   localparam logic [1:0] TBA_FO = 2'h0;
   localparam logic [7:0] TBA_APPDATA = 8'h00;
   localparam logic [3:0] TBA_ANS_LAST = 4'hb;
   // Tag states
   typedef enum logic [1:0] {
      TBA_IDLE = 2'b00,
      TBA_READY = 2'b01,
      TBA_HALT = 2'b10
   } tba_state_t;
endpackage

// File: tba_atqb_rom.sv
// Answer byte table with registered read data
`timescale 1ns/1ps
module tba_atqb_rom (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Byte select
   input wire logic [3:0] addr,
   // Variable fields
   input wire logic [31:0] pupi,
   input wire logic [3:0] fwi,
   // Byte out
   output logic [7:0] data_reg
);
   logic [7:0] data_next;

   always_comb begin
      unique case (addr)
         4'h0: data_next = tba_pkg::TBA_ANS_CODE;
         4'h1: data_next = pupi[31:24];
         4'h2: data_next = pupi[23:16];
         4'h3: data_next = pupi[15:8];
         4'h4: data_next = pupi[7:0];
         // [R7] Zero application data
         4'h5, 4'h6, 4'h7, 4'h8: data_next = tba_pkg::TBA_APPDATA;
         // [R8] Rate byte
         4'h9: data_next = tba_pkg::TBA_PROTO1;
         // [R9] [R10] Frame size and protocol
         4'ha: data_next = {tba_pkg::TBA_MAXFRAME, tba_pkg::TBA_PROTYPE};
         // [R12] [R13] [R14] Wait integer, coding, options
         4'hb: data_next = {fwi, tba_pkg::TBA_ADC, tba_pkg::TBA_FO};
         default: data_next = 8'h00;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_reg <= 8'h00;
      end else begin
         data_reg <= data_next;
      end
   end
endmodule

// File: tba_request_answer_chk.sv
// Assertion checker for the TypeB request answer block
`timescale 1ns/1ps
module tba_request_answer_chk (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Request and answer links
   input wire logic rx_valid,
   input wire logic rx_last,
   input wire logic rx_crc_ok,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic tx_last,
   input wire logic tx_ready
);
   logic [3:0] pos_reg;
   // Index of the answer byte on offer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pos_reg <= 4'h0;
      end else if (tx_valid && tx_ready) begin
         pos_reg <= tx_last ? 4'h0 : pos_reg + 4'h1;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_first_byte: assert property ($rose(tx_valid) |-> tx_data == 8'h50)
      else $error("answer does not open with its code");
   a_data_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("answer byte changed while stalled");
   a_crc_drop: assert property (rx_valid && rx_last && !rx_crc_ok && !tx_valid |=> !tx_valid)
      else $error("answer to bad check bytes");
   a_app_zero: assert property (tx_valid && pos_reg inside {[5:8]} |-> tx_data == 8'h00)
      else $error("application byte not zero");
   a_proto_one: assert property (tx_valid && pos_reg == 4'h9 |-> tx_data == 8'h91)
      else $error("first protocol byte wrong");
   a_proto_two: assert property (tx_valid && pos_reg == 4'ha |-> tx_data == 8'h81)
      else $error("second protocol byte wrong");
   a_third_low: assert property (tx_last |-> tx_valid && tx_data[3:0] == 4'h0)
      else $error("third protocol byte low nibble not zero");
   a_last_pos: assert property (tx_valid |-> tx_last == (pos_reg == 4'hb))
      else $error("last flag on wrong byte");
endmodule
bind tba_request_answer tba_request_answer_chk tba_request_answer_chk_i (.pclk(pclk),
   .presetn(presetn), .rx_valid(rx_valid), .rx_last(rx_last), .rx_crc_ok(rx_crc_ok),
   .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready));

// File: tba_reader_model.sv
// Reader model that sends request frames and takes answer bytes with stalls
`timescale 1ns/1ps
module tba_reader_model (
   // Clock
   input wire logic pclk,
   // Request link
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic rx_last,
   output logic rx_crc_ok,
   // Answer link
   output logic tx_ready
);
   initial begin
      {rx_valid, rx_last, rx_crc_ok, tx_ready} = 4'h0;
      rx_data = 8'h00;
   end
   // Takes a byte only every other cycle
   always @(posedge pclk) tx_ready <= ~tx_ready;
   task automatic send(input logic [7:0] afi, input logic [7:0] par, input logic good);
      logic [7:0] f [5];
      f = '{8'h05, afi, par, 8'h3c, 8'hc3};
      // Guard gap before the next command
      repeat (12) @(posedge pclk);
      // Code, family, parameter, two check bytes
      for (int i = 0; i < 5; i++) begin
         @(posedge pclk);
         rx_valid <= 1'b1;
         rx_data <= f[i];
         rx_last <= (i == 4);
         rx_crc_ok <= good && (i == 4);
      end
      @(posedge pclk);
      {rx_valid, rx_last, rx_crc_ok} <= 3'h0;
      rx_data <= ~f[4];
   endtask
endmodule

// File: tb_tba_request_answer.sv
// Testbench for the TypeB request answer block
`timescale 1ns/1ps
module tb_tba_request_answer;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr, rx_data, tx_data;
   logic [31:0] pwdata, prdata, rd;
   logic rx_valid, rx_last, rx_crc_ok, tx_valid, tx_last, tx_ready;
   int error_cnt = 0;
   int n_checks = 0;
   tba_request_answer tba_request_answer_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_last(rx_last), .rx_crc_ok(rx_crc_ok), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_last(tx_last), .tx_ready(tx_ready));
   tba_reader_model tba_reader_model_i (.pclk(pclk), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_last(rx_last), .rx_crc_ok(rx_crc_ok), .tx_ready(tx_ready));
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic ask(input logic [7:0] afi, par, input logic good, ans, input logic [3:0] fwi);
      logic [7:0] e [12];
      e = '{8'h50, 8'h12, 8'h34, 8'h56, 8'h78, 0, 0, 0, 0, 8'h91, 8'h81, {fwi, 4'h0}};
      tba_reader_model_i.send(afi, par, good);
      @(negedge pclk);
      chk("answer", ans, tx_valid);
      // Answer wait bounded only by the watchdog
      for (int i = 0; ans && i < 12; i++) begin
         while (!(tx_valid && tx_ready)) @(negedge pclk);
         chk("byte", e[i], tx_data);
         chk("last", i == 11, tx_last);
         @(negedge pclk);
      end
      @(posedge pclk);
      if (ans) apb(1'b1, tba_pkg::TBA_CMD_OFF, 32'h1);
   endtask
   task automatic s_regs();
      apb(1'b0, tba_pkg::TBA_CTRL_OFF, 32'h0);
      chk("ctrl", tba_pkg::TBA_CTRL_RST, rd);
      apb(1'b1, tba_pkg::TBA_PUPI_OFF, 32'h1234_5678);
      apb(1'b0, tba_pkg::TBA_PUPI_OFF, 32'h0);
      chk("pupi", 32'h1234_5678, rd);
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped", 32'h1, {rd[31:1], err});
   endtask
   task automatic s_slots();
      for (int p = 0; p < 8; p++) ask(8'h00, 8'ha0 | p[7:0], 1'b1, 1'b1, 4'h0);
   endtask
   task automatic s_family();
      apb(1'b1, tba_pkg::TBA_CTRL_OFF, 32'h0000_03e1);
      ask(8'h03, 8'h00, 1'b1, 1'b1, 4'he);
      ask(8'h04, 8'h00, 1'b1, 1'b0, 4'he);
   endtask
   task automatic s_halt();
      apb(1'b1, tba_pkg::TBA_CMD_OFF, 32'h2);
      apb(1'b0, tba_pkg::TBA_STAT_OFF, 32'h0);
      chk("status", 32'h0000_0902, rd);
      ask(8'h00, 8'h00, 1'b1, 1'b0, 4'he);
      ask(8'h00, 8'h08, 1'b1, 1'b1, 4'he);
      ask(8'h00, 8'h08, 1'b1, 1'b1, 4'he);
      ask(8'h00, 8'h00, 1'b0, 1'b0, 4'he);
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      {presetn, psel, penable, pwrite} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      s_regs();
      s_slots();
      s_family();
      s_halt();
      close_out();
   end
   initial begin
      repeat (20000) @(posedge pclk);
      error_cnt++;
      close_out();
   end
endmodule
